// >>> ebha_arbiter.sv
// External bus hold arbiter: hands the external memory bus to an outside master.
`timescale 1ns/1ps
module ebha_arbiter
  import ebha_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ext_hold_req_n,
  input wire logic go_mode_en,
  input wire logic mem_need,
  input wire logic byte_mem_dma_need,
  input wire logic access_busy,
  input wire logic access_end,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [DATA_W-1:0] core_wdata,
  input wire logic core_wdata_en,
  input wire logic [STROBE_W-1:0] core_strobe_n,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] core_rdata,
  output logic hold_grant_n,
  output logic grant_hung_n,
  output logic core_halt,
  output logic access_allow,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  output logic [STROBE_W-1:0] strobe_o,
  output logic strobe_oe
);

  ebha_drv_if drv_bus ();

  ebha_state_e state_q, state_d;
  logic grant_n_q, grant_n_d;
  logic hung_n_q, hung_n_d;
  logic halt_q, halt_d;
  logic allow_q, allow_d;
  logic hold_req;
  logic ext_need;

  // The outside master owns the bus while its request stays low.
  assign hold_req = ~ext_hold_req_n;
  // A stall that needs the bus counts for either a core access or a byte DMA access.
  assign ext_need = mem_need | byte_mem_dma_need;

  // An access counts as still running unless this is its last cycle.
  function automatic logic access_open(input logic busy, input logic last);
    access_open = busy & ~last;
  endfunction

  always_comb
  begin
    state_d = state_q;
    if (srst)
    begin
      // Reset clears the access context, yet the request is still served.
      state_d = hold_req ? EBHA_GRANT : EBHA_OWN;
    end
    else
    begin
      case (state_q)
        EBHA_OWN:
        begin
          if (hold_req)
          begin
            if (access_open(access_busy, access_end))
            begin
              state_d = EBHA_DRAIN;
            end
            else
            begin
              state_d = EBHA_GRANT;
            end
          end
        end
        EBHA_DRAIN:
        begin
          if (!hold_req)
          begin
            state_d = EBHA_OWN;
          end
          else if (!access_open(access_busy, access_end))
          begin
            // The grant lands in the cycle after the access ends, before any next access of the same instruction.
            state_d = EBHA_GRANT;
          end
        end
        EBHA_GRANT:
        begin
          if (!hold_req)
          begin
            state_d = EBHA_OWN;
          end
        end
        default:
        begin
          state_d = EBHA_OWN;
        end
      endcase
    end
  end

  always_comb
  begin
    grant_n_d = (state_d != EBHA_GRANT);
    // Leaving the grant state drops both outputs on the same edge, before the pending access may start.
    hung_n_d = ~((state_d == EBHA_GRANT) & ext_need);
    if (state_d == EBHA_GRANT)
    begin
      // Without run-while-granted the core halts at once; with it, only once it needs the bus.
      halt_d = go_mode_en ? ext_need : 1'b1;
    end
    else
    begin
      halt_d = 1'b0;
    end
    // A new access may start only while the core owns the bus and no request waits.
    // Blocking it during a pending request is what puts the grant between two accesses.
    allow_d = (state_d == EBHA_OWN) & ~hold_req & ~srst;
  end

  always_ff @(posedge clk)
  begin
    // Reset is folded into the next-state logic, since the arbiter must keep working through it.
    state_q <= state_d;
    grant_n_q <= grant_n_d;
    hung_n_q <= hung_n_d;
    halt_q <= halt_d;
    allow_q <= allow_d;
  end

  assign drv_bus.drive_d = (state_d != EBHA_GRANT);
  assign drv_bus.addr = core_addr;
  assign drv_bus.wdata = core_wdata;
  assign drv_bus.wdata_en = core_wdata_en;
  assign drv_bus.strobe_n = core_strobe_n;
  assign drv_bus.data_i = data_i;

  ebha_pin_drv u_pin_drv (
    .clk(clk),
    .srst(srst),
    .pins(drv_bus.drv)
  );

  assign hold_grant_n = grant_n_q;
  assign grant_hung_n = hung_n_q;
  assign core_halt = halt_q;
  assign access_allow = allow_q;
  assign core_rdata = drv_bus.rdata;
  assign addr_o = drv_bus.addr_o;
  assign addr_oe = drv_bus.addr_oe;
  assign data_o = drv_bus.data_o;
  assign data_oe = drv_bus.data_oe;
  assign strobe_o = drv_bus.strobe_o;
  assign strobe_oe = drv_bus.strobe_oe;

endmodule

// >>> ebha_assertions.sv
// Port checker for the external bus hold arbiter.
`timescale 1ns/1ps
module ebha_assertions
  import ebha_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ext_hold_req_n,
  input wire logic go_mode_en,
  input wire logic mem_need,
  input wire logic byte_mem_dma_need,
  input wire logic access_busy,
  input wire logic access_end,
  input wire logic hold_grant_n,
  input wire logic grant_hung_n,
  input wire logic core_halt,
  input wire logic access_allow,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic [STROBE_W-1:0] strobe_o,
  input wire logic strobe_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire need = mem_need | byte_mem_dma_need;
  wire open_acc = access_busy & ~access_end;
  a_grant_when_idle: assert property (!ext_hold_req_n && !open_acc |=> !hold_grant_n)
    else $error("grant late");
  a_wait_open: assert property (!ext_hold_req_n && open_acc && hold_grant_n |=> hold_grant_n && addr_oe)
    else $error("grant during access");
  a_release_all: assert property (ext_hold_req_n |=> hold_grant_n && grant_hung_n && strobe_oe && !core_halt)
    else $error("release incomplete");
  a_float_grant: assert property (!hold_grant_n |-> !addr_oe && !data_oe && !strobe_oe && strobe_o == STROBE_IDLE)
    else $error("driving while granted");
  a_hung_need: assert property (!ext_hold_req_n && !hold_grant_n && need |=> !grant_hung_n && core_halt)
    else $error("hung missing");
  a_hung_granted: assert property (hold_grant_n |-> grant_hung_n)
    else $error("hung without grant");
  a_go_runs: assert property (!ext_hold_req_n && !hold_grant_n && go_mode_en && !need |=> !core_halt)
    else $error("core halted in go mode");
  a_halt_mode: assert property (!ext_hold_req_n && !hold_grant_n && !go_mode_en |=> core_halt)
    else $error("core not halted");
  a_allow_stop: assert property (!ext_hold_req_n |=> !access_allow)
    else $error("access allowed");
  c_grant: cover property (!hold_grant_n);
  c_hung: cover property (!grant_hung_n);
  c_wait: cover property (!ext_hold_req_n && open_acc);
endmodule

// >>> ebha_drv_if.sv
// Interface between the arbiter core and its pin driver stage.
`timescale 1ns/1ps
interface ebha_drv_if
  import ebha_pkg::*;
();
  logic drive_d;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wdata_en;
  logic [STROBE_W-1:0] strobe_n;
  logic [DATA_W-1:0] data_i;
  logic [ADDR_W-1:0] addr_o;
  logic addr_oe;
  logic [DATA_W-1:0] data_o;
  logic data_oe;
  logic [STROBE_W-1:0] strobe_o;
  logic strobe_oe;
  logic [DATA_W-1:0] rdata;

  modport arb (
    output drive_d,
    output addr,
    output wdata,
    output wdata_en,
    output strobe_n,
    output data_i,
    input addr_o,
    input addr_oe,
    input data_o,
    input data_oe,
    input strobe_o,
    input strobe_oe,
    input rdata
  );

  modport drv (
    input drive_d,
    input addr,
    input wdata,
    input wdata_en,
    input strobe_n,
    input data_i,
    output addr_o,
    output addr_oe,
    output data_o,
    output data_oe,
    output strobe_o,
    output strobe_oe,
    output rdata
  );
endinterface

// >>> ebha_master.sv
// Model of the outside master that borrows the memory bus.
`timescale 1ns/1ps
module ebha_master (
  input wire logic clk,
  input wire logic want,
  input wire logic give_on_hung,
  input wire logic hold_grant_n,
  input wire logic grant_hung_n,
  output logic ext_hold_req_n = 1'b1,
  output logic bus_drive = 1'b0
);
  logic gave = 1'b0;
  // The request is released only after driving stopped, so the lines never clash.
  always @(posedge clk)
  begin
    gave <= want && (gave || give_on_hung && !grant_hung_n);
    bus_drive <= want && !gave && !hold_grant_n && !ext_hold_req_n;
    if (want && !gave)
      ext_hold_req_n <= 1'b0;
    else if (!bus_drive)
      ext_hold_req_n <= 1'b1;
  end
endmodule

// >>> ebha_pin_drv.sv
// Pin driver stage for the external address, data and strobe lines.
`timescale 1ns/1ps
module ebha_pin_drv
  import ebha_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  ebha_drv_if.drv pins
);

  logic [ADDR_W-1:0] addr_q, addr_d;
  logic addr_oe_q, addr_oe_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic data_oe_q, data_oe_d;
  logic [STROBE_W-1:0] strobe_q, strobe_d;
  logic strobe_oe_q, strobe_oe_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  always_comb
  begin
    // The enables switch on the same edge as the grant flop, so no cycle exists in which both masters drive.
    addr_oe_d = pins.drive_d;
    strobe_oe_d = pins.drive_d;
    data_oe_d = pins.drive_d & pins.wdata_en;
    addr_d = pins.addr;
    data_d = pins.wdata;
    // While floated, the strobe values are parked idle, so they read inactive for the whole grant.
    strobe_d = pins.drive_d ? pins.strobe_n : STROBE_IDLE;
    rdata_d = pins.data_i;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addr_q <= '0;
      data_q <= '0;
      strobe_q <= STROBE_IDLE;
      rdata_q <= '0;
    end
    else
    begin
      addr_q <= addr_d;
      data_q <= data_d;
      strobe_q <= strobe_d;
      rdata_q <= rdata_d;
    end
    // Enables follow the arbiter even in reset, because requests are served then too.
    addr_oe_q <= addr_oe_d;
    data_oe_q <= data_oe_d;
    strobe_oe_q <= strobe_oe_d;
  end

  assign pins.addr_o = addr_q;
  assign pins.addr_oe = addr_oe_q;
  assign pins.data_o = data_q;
  assign pins.data_oe = data_oe_q;
  assign pins.strobe_o = strobe_q;
  assign pins.strobe_oe = strobe_oe_q;
  assign pins.rdata = rdata_q;

endmodule

// >>> ebha_pkg.sv
// Package with the constants and types of the external bus hold arbiter.
// Function
// - With the request active and no external access under way, the next cycle floats address, data and strobes and asserts the grant;
//   without run-while-granted it also halts the core.
// - With run-while-granted enabled, the core keeps running after the grant and stops only when it needs an external access.
// - An external access under way when the request arrives is completed first, and the grant follows in the cycle after that access ends.
// - The grant is given at an access boundary, so it may fall between the two accesses of one instruction.
// - When the request is released the grant is dropped, the drivers are turned on again and execution resumes where it stopped.
// - Hold requests are served at all times, during boot and while reset is asserted.
// - While the bus is granted away, the active-low grant-hung output is asserted whenever the core is stalled needing a memory or byte-memory DMA access.
// - Once the bus is returned, grant and grant-hung are both dropped and the pending external access is then carried out.
package ebha_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int STROBE_W = 7;

  // Strobe bit positions within the strobe vector.
  localparam int STB_PROG_MEM = 0;
  localparam int STB_DATA_MEM = 1;
  localparam int STB_BYTE_MEM = 2;
  localparam int STB_COMPOSITE = 3;
  localparam int STB_IO_SPACE = 4;
  localparam int STB_RD = 5;
  localparam int STB_WR = 6;

  // All strobes are active low, so the idle pattern is all ones.
  localparam logic [STROBE_W-1:0] STROBE_IDLE = 7'h7f;

  // Cycles from a served request to the grant, and from release to grant drop.
  localparam int GRANT_LATENCY = 1;
  localparam int RELEASE_LATENCY = 1;

  typedef enum logic [1:0] {
    EBHA_OWN,
    EBHA_DRAIN,
    EBHA_GRANT
  } ebha_state_e;

endpackage

// >>> tb_ebha_arbiter.sv
// Self-checking bench for the external bus hold arbiter.
`timescale 1ns/1ps
module tb_ebha_arbiter
  import ebha_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, go_mode_en = 1'b0, mem_need = 1'b0, byte_mem_dma_need = 1'b0;
  logic access_busy = 1'b0, access_end = 1'b0, core_wdata_en = 1'b0, want = 1'b0, give_on_hung = 1'b0;
  logic hold_grant_n, grant_hung_n, core_halt, access_allow, addr_oe, data_oe, strobe_oe, ext_hold_req_n, bus_drive;
  logic [ADDR_W-1:0] core_addr = '0, addr_o;
  logic [DATA_W-1:0] core_wdata = '0, data_i = '0, core_rdata, data_o;
  logic [STROBE_W-1:0] core_strobe_n = STROBE_IDLE, strobe_o;
  logic [31:0] rnd = 32'h18;
  // Pin values expected one edge after the core presents them.
  logic [DATA_W-1:0] exp_rdata = '0, exp_wdata = '0;
  logic [ADDR_W-1:0] exp_addr = '0;
  logic [STROBE_W-1:0] exp_strobe = STROBE_IDLE;
  logic exp_wen = 1'b0;
  int n_fail = 0, comparisons = 0;
  ebha_arbiter u_ebha_arbiter (.*);
  ebha_master u_ebha_master (.*);
  always #10 clk = ~clk;
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic exp_halt(input logic go, input logic need);
    return !go || need;
  endfunction
  initial
  begin
    @(posedge clk) want <= 1'b1;
    cyc(2);
    chk("grant_in_reset", {hold_grant_n, addr_oe}, 0);
    @(posedge clk) {srst, want} <= 2'h0;
    cyc(4);
    chk("reset_release", {hold_grant_n, access_allow, strobe_oe}, 3'h7);
    $display("test reset done");
    @(posedge clk) want <= 1'b1;
    cyc(3);
    chk("halt", {hold_grant_n, core_halt}, {1'b0, exp_halt(go_mode_en, 1'b0)});
    chk("strobe_float", {strobe_oe, strobe_o}, {1'b0, STROBE_IDLE});
    @(posedge clk) want <= 1'b0;
    cyc(4);
    chk("release", {hold_grant_n, core_halt, addr_oe}, 3'h5);
    $display("test halt done");
    @(posedge clk) {access_busy, want} <= 2'h3;
    cyc(4);
    chk("held_by_access", {hold_grant_n, addr_oe, access_allow}, 3'h6);
    @(posedge clk) access_end <= 1'b1;
    @(posedge clk) {access_busy, access_end} <= 2'h0;
    #1;
    chk("boundary_grant", hold_grant_n, 0);
    @(posedge clk) want <= 1'b0;
    cyc(4);
    $display("test access done");
    @(posedge clk) {go_mode_en, give_on_hung, want} <= 3'h7;
    cyc(3);
    chk("go_runs", {hold_grant_n, core_halt, grant_hung_n}, {2'h0, 1'b1});
    @(posedge clk) byte_mem_dma_need <= 1'b1;
    cyc(1);
    chk("hung", {grant_hung_n, core_halt}, {1'b0, exp_halt(1'b1, 1'b1)});
    cyc(4);
    chk("returned", {hold_grant_n, grant_hung_n, addr_oe}, 3'h7);
    @(posedge clk) {byte_mem_dma_need, want} <= 2'h0;
    $display("test go done");
    repeat (400)
    begin
      @(posedge clk);
      rnd = xs(rnd);
      {want, go_mode_en, mem_need, byte_mem_dma_need, give_on_hung} <= rnd[4:0];
      {core_wdata_en, core_strobe_n, core_wdata} <= rnd;
      {core_addr, data_i} <= {rnd[13:0], rnd[31:8]};
      #1;
      chk("float_on_grant", !hold_grant_n && addr_oe, 0);
      chk("hung_needs_grant", hold_grant_n && !grant_hung_n, 0);
      chk("master_drive", bus_drive && hold_grant_n, 0);
      chk("addr_pins", addr_o, exp_addr);
      chk("data_pins", data_o, exp_wdata);
      chk("data_enable", data_oe, hold_grant_n && exp_wen);
      chk("strobe_pins", strobe_o, hold_grant_n ? exp_strobe : STROBE_IDLE);
      chk("read_data", core_rdata, exp_rdata);
      {exp_wen, exp_strobe, exp_wdata} = rnd;
      {exp_addr, exp_rdata} = {rnd[13:0], rnd[31:8]};
    end
    $display("test random done");
    final_report();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
bind ebha_arbiter ebha_assertions u_ebha_assertions (.*);
